// file: include/ipc_pkg.sv
// package: register map, field layout and field carriers for the priority configuration block
package ipc_pkg;
    // register byte addresses (word aligned)
    localparam logic [3:0] GRP_ONE_ADDR = 4'h0;
    localparam logic [3:0] GRP_TWO_ADDR = 4'h4;
    localparam logic [3:0] ADDR_MASK    = 4'hc;

    // byte slots within each register, top byte first
    localparam int SLOT_EXT = 3;
    localparam int SLOT_OUT = 2;
    localparam int SLOT_CAP = 1;
    localparam int SLOT_TMR = 0;

    // field positions inside one byte slot
    localparam int SUB_LSB  = 0;
    localparam int PRI_LSB  = 2;
    localparam int RSV_LSB  = 5;

    // bits writable per register, all others reserved and read as zero
    localparam logic [31:0] FIELD_MASK = 32'h1f1f_1f1f;
    localparam logic [31:0] RESET_VAL  = 32'h0000_0000;

    localparam logic [2:0] PRI_DISABLED = 3'h0;

    typedef struct packed {
        logic [2:0] priority_level;
        logic [1:0] subpriority;
    } ipc_src_cfg_t;

    // one register worth of configuration: external, output compare, input capture, timer
    typedef struct packed {
        ipc_src_cfg_t ext_irq;
        ipc_src_cfg_t out_cmp;
        ipc_src_cfg_t in_cap;
        ipc_src_cfg_t timer;
    } ipc_group_cfg_t;

    // per-source view handed to arbitration
    typedef struct packed {
        logic       enabled;
        logic [2:0] priority_level;
        logic [1:0] subpriority;
    } ipc_src_view_t;
endpackage : ipc_pkg

// file: hw/ipc_src_decode.sv
// leaf: turns one group register into per-source fields for arbitration
`timescale 1ns/100ps
module ipc_src_decode (
    input  wire logic [31:0]           group_word_in,
    output ipc_pkg::ipc_group_cfg_t    group_cfg_out
);
    function automatic ipc_pkg::ipc_src_cfg_t slot_fields(input logic [7:0] slot);
        ipc_pkg::ipc_src_cfg_t f;
        f.priority_level = slot[ipc_pkg::PRI_LSB +: 3];
        f.subpriority    = slot[ipc_pkg::SUB_LSB +: 2];
        return f;
    endfunction : slot_fields

    always_comb begin
        group_cfg_out.ext_irq = slot_fields(group_word_in[ipc_pkg::SLOT_EXT*8 +: 8]);
        group_cfg_out.out_cmp = slot_fields(group_word_in[ipc_pkg::SLOT_OUT*8 +: 8]);
        group_cfg_out.in_cap  = slot_fields(group_word_in[ipc_pkg::SLOT_CAP*8 +: 8]);
        group_cfg_out.timer   = slot_fields(group_word_in[ipc_pkg::SLOT_TMR*8 +: 8]);
    end
endmodule : ipc_src_decode

// file: hw/ipc_priority_regs.sv
// top: two source priority configuration registers behind an Avalon-MM slave
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/100ps
module ipc_priority_regs (
    // clock and reset
    input  wire logic                   SYS_CLK_IN,
    input  wire logic                   RST_IN,
    // avalon-mm slave
    input  wire logic [3:0]             AVS_ADDRESS_IN,
    input  wire logic                   AVS_READ_IN,
    input  wire logic                   AVS_WRITE_IN,
    input  wire logic [31:0]            AVS_WRITEDATA_IN,
    input  wire logic [3:0]             AVS_BYTEENABLE_IN,
    output logic [31:0]                 AVS_READDATA_OUT,
    output logic                        AVS_WAITREQUEST_OUT,
    output logic [1:0]                  AVS_RESPONSE_OUT,
    // per-source configuration to arbitration, four sources per group
    output ipc_pkg::ipc_src_view_t [3:0] GRP_ONE_SRC_OUT,
    output ipc_pkg::ipc_src_view_t [3:0] GRP_TWO_SRC_OUT
);
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;

    typedef enum logic [0:0] {
        IPC_IDLE   = 1'b0,
        IPC_ANSWER = 1'b1
    } ipc_bus_state_t;

    logic [31:0]            grp_one_q, grp_one_d;
    logic [31:0]            grp_two_q, grp_two_d;
    ipc_bus_state_t         state_q, state_d;
    logic [31:0]            rdata_q, rdata_d;
    logic [1:0]             resp_q, resp_d;
    logic                   waitreq_q, waitreq_d;
    ipc_pkg::ipc_group_cfg_t cfg_one, cfg_two;
    ipc_pkg::ipc_src_view_t [3:0] view_one_q, view_one_d, view_two_q, view_two_d;

    // merge byte-enabled write data, reserved bits forced to zero
    function automatic logic [31:0] merge_wr(input logic [31:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r & ipc_pkg::FIELD_MASK;
    endfunction : merge_wr

    function automatic ipc_pkg::ipc_src_view_t to_view(input ipc_pkg::ipc_src_cfg_t c);
        ipc_pkg::ipc_src_view_t v;
        v.enabled        = (c.priority_level != ipc_pkg::PRI_DISABLED);
        v.priority_level = c.priority_level;
        v.subpriority    = c.subpriority;
        return v;
    endfunction : to_view

    // bus slave: one wait cycle, answer in the second cycle
    always_comb begin
        state_d   = state_q;
        grp_one_d = grp_one_q;
        grp_two_d = grp_two_q;
        rdata_d   = rdata_q;
        resp_d    = resp_q;
        case (state_q)
            IPC_IDLE: begin
                if (AVS_READ_IN || AVS_WRITE_IN) begin
                    state_d = IPC_ANSWER;
                    resp_d  = RESP_OKAY;
                    rdata_d = 32'h0000_0000;
                    if ((AVS_ADDRESS_IN & ipc_pkg::ADDR_MASK) == ipc_pkg::GRP_ONE_ADDR) begin
                        if (AVS_WRITE_IN) begin
                            grp_one_d = merge_wr(grp_one_q, AVS_WRITEDATA_IN,
                                                 AVS_BYTEENABLE_IN);
                        end else begin
                            rdata_d = grp_one_q;
                        end
                    end else if ((AVS_ADDRESS_IN & ipc_pkg::ADDR_MASK)
                                 == ipc_pkg::GRP_TWO_ADDR) begin
                        if (AVS_WRITE_IN) begin
                            grp_two_d = merge_wr(grp_two_q, AVS_WRITEDATA_IN,
                                                 AVS_BYTEENABLE_IN);
                        end else begin
                            rdata_d = grp_two_q;
                        end
                    end else begin
                        resp_d = RESP_DECERR;
                    end
                end
            end
            IPC_ANSWER: begin
                state_d = IPC_IDLE;
            end
            default: begin
                state_d = IPC_IDLE;
            end
        endcase
        // waitrequest drops only in the answer cycle, kept in its own flop
        waitreq_d = (state_d != IPC_ANSWER);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state_q   <= IPC_IDLE;
            grp_one_q <= ipc_pkg::RESET_VAL;
            grp_two_q <= ipc_pkg::RESET_VAL;
            rdata_q   <= 32'h0000_0000;
            resp_q    <= RESP_OKAY;
            waitreq_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            grp_one_q <= grp_one_d;
            grp_two_q <= grp_two_d;
            rdata_q   <= rdata_d;
            resp_q    <= resp_d;
            waitreq_q <= waitreq_d;
        end
    end

    ipc_src_decode u_dec_one (
        .group_word_in (grp_one_q),
        .group_cfg_out (cfg_one)
    );

    ipc_src_decode u_dec_two (
        .group_word_in (grp_two_q),
        .group_cfg_out (cfg_two)
    );

    // source views: index 3 external, 2 output compare, 1 input capture, 0 timer
    always_comb begin
        view_one_d[3] = to_view(cfg_one.ext_irq);
        view_one_d[2] = to_view(cfg_one.out_cmp);
        view_one_d[1] = to_view(cfg_one.in_cap);
        view_one_d[0] = to_view(cfg_one.timer);
        view_two_d[3] = to_view(cfg_two.ext_irq);
        view_two_d[2] = to_view(cfg_two.out_cmp);
        view_two_d[1] = to_view(cfg_two.in_cap);
        view_two_d[0] = to_view(cfg_two.timer);
    end

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            view_one_q <= '0;
            view_two_q <= '0;
        end else begin
            view_one_q <= view_one_d;
            view_two_q <= view_two_d;
        end
    end

    assign AVS_READDATA_OUT    = rdata_q;
    assign AVS_RESPONSE_OUT    = resp_q;
    assign AVS_WAITREQUEST_OUT = waitreq_q;
    assign GRP_ONE_SRC_OUT     = view_one_q;
    assign GRP_TWO_SRC_OUT     = view_two_q;

    // assertions
    AST_DISABLED_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        GRP_ONE_SRC_OUT[1].enabled == (GRP_ONE_SRC_OUT[1].priority_level != 3'h0))
        else $error("enable flag disagrees with priority code");
    AST_PRI_LEVEL: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        GRP_TWO_SRC_OUT[3].priority_level == $past(grp_two_q[28:26]))
        else $error("external priority level wrong");
    AST_SUB_LEVEL: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        GRP_TWO_SRC_OUT[0].subpriority == $past(grp_two_q[1:0]))
        else $error("timer subpriority wrong");
    AST_RSV_ZERO: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        ((grp_one_q | grp_two_q) & ~ipc_pkg::FIELD_MASK) == 32'h0)
        else $error("reserved bit set");
    AST_CAP_FIELD: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_q == IPC_IDLE && AVS_WRITE_IN && AVS_ADDRESS_IN == 4'h0
         && AVS_BYTEENABLE_IN[1])
        |=> grp_one_q[12:8] == $past(AVS_WRITEDATA_IN[12:8]))
        else $error("input capture field not written");
    AST_TMR_FIELD: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_q == IPC_IDLE && AVS_WRITE_IN && AVS_ADDRESS_IN == 4'h0
         && AVS_BYTEENABLE_IN[0])
        |=> ##1 GRP_ONE_SRC_OUT[0].priority_level == $past(AVS_WRITEDATA_IN[4:2], 2))
        else $error("timer priority not visible two cycles after write");
    AST_EXT_FIELD: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        GRP_ONE_SRC_OUT[3].subpriority == $past(grp_one_q[25:24]))
        else $error("external subpriority wrong");
    AST_OC_FIELD: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        GRP_ONE_SRC_OUT[2].priority_level == $past(grp_one_q[20:18]))
        else $error("output compare priority wrong");
    AST_OC_SUB: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        $changed(grp_two_q[17:16]) |=> GRP_TWO_SRC_OUT[2].subpriority == $past(grp_two_q[17:16]))
        else $error("output compare subpriority late");
    AST_ANSWER_ONE_WAIT: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (state_q == IPC_IDLE && (AVS_READ_IN || AVS_WRITE_IN)) |=> !AVS_WAITREQUEST_OUT)
        else $error("answer not in second cycle");
    COV_WRITE_ONE: cover property (@(posedge SYS_CLK_IN)
        AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h0);
    COV_READ_TWO: cover property (@(posedge SYS_CLK_IN)
        AVS_READ_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == 4'h4);
    COV_DECERR: cover property (@(posedge SYS_CLK_IN) AVS_RESPONSE_OUT == 2'h3);
    COV_ENABLED: cover property (@(posedge SYS_CLK_IN) GRP_TWO_SRC_OUT[3].enabled);
endmodule : ipc_priority_regs

// file: testbench/ipc_priority_regs_tb.sv
// testbench: register access and source view checks for the priority block
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module ipc_priority_regs_tb;
    logic                         clk;
    logic                         rst;
    logic [3:0]                   addr;
    logic                         rd;
    logic                         wr;
    logic [31:0]                  wdata;
    logic [3:0]                   ben;
    logic [31:0]                  rdata;
    logic                         waitreq;
    logic [1:0]                   resp;
    ipc_pkg::ipc_src_view_t [3:0] src1;
    ipc_pkg::ipc_src_view_t [3:0] src2;
    logic [31:0]                  got;
    logic [1:0]                   got_rsp;
    int                           err_count = 0;
    int                           n_compared = 0;

    ipc_priority_regs u_dut (
        .SYS_CLK_IN          (clk),
        .RST_IN              (rst),
        .AVS_ADDRESS_IN      (addr),
        .AVS_READ_IN         (rd),
        .AVS_WRITE_IN        (wr),
        .AVS_WRITEDATA_IN    (wdata),
        .AVS_BYTEENABLE_IN   (ben),
        .AVS_READDATA_OUT    (rdata),
        .AVS_WAITREQUEST_OUT (waitreq),
        .AVS_RESPONSE_OUT    (resp),
        .GRP_ONE_SRC_OUT     (src1),
        .GRP_TWO_SRC_OUT     (src2)
    );

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    function automatic logic [5:0] view_of(input logic [2:0] p, input logic [1:0] s);
        return {p != 3'h0, p, s};
    endfunction : view_of

    // request held until waitrequest is sampled low at a rising edge, released there
    task automatic bus(input logic r, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] b);
        int n;
        n = 0;
        @(posedge clk);
        rd    <= r;
        wr    <= !r;
        addr  <= a;
        wdata <= d;
        ben   <= b;
        @(posedge clk);
        n = 1;
        while (waitreq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (waitreq !== 1'b0) begin
            err_count++;
            report_and_stop();
        end
        got     = rdata;
        got_rsp = resp;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task automatic reset_values;
        bus(1'b1, ipc_pkg::GRP_ONE_ADDR, 32'h0, 4'hf);
        `CHK(got, ipc_pkg::RESET_VAL)
        `CHK(got_rsp, 2'h0)
        bus(1'b1, ipc_pkg::GRP_TWO_ADDR, 32'h0, 4'hf);
        `CHK(got, ipc_pkg::RESET_VAL)
        `CHK({src1, src2}, 48'h0)
    endtask : reset_values

    // every priority code, subpriority following the low bits
    task automatic code_sweep;
        for (int i = 0; i < 8; i++) begin
            bus(1'b0, ipc_pkg::GRP_TWO_ADDR, {27'h0, i[2:0], i[1:0]}, 4'h1);
            @(negedge clk);
            `CHK(src2[0], view_of(i[2:0], i[1:0]))
            `CHK(src2[0].enabled, i != 0)
            `CHK(src2[0].subpriority, i[1:0])
        end
    endtask : code_sweep

    // every field of both registers, reserved bits written as zero
    task automatic layout;
        bus(1'b0, ipc_pkg::GRP_ONE_ADDR, 32'h150a_1f03, 4'hf);
        @(negedge clk);
        `CHK(src1[3], view_of(3'h5, 2'h1))
        `CHK(src1[2], view_of(3'h2, 2'h2))
        `CHK(src1[1], view_of(3'h7, 2'h3))
        `CHK(src1[0], view_of(3'h0, 2'h3))
        bus(1'b1, ipc_pkg::GRP_ONE_ADDR, 32'h0, 4'hf);
        `CHK(got, 32'h150a_1f03)
        bus(1'b0, ipc_pkg::GRP_TWO_ADDR, 32'h061d_0812, 4'hf);
        @(negedge clk);
        `CHK(src2, {view_of(3'h1, 2'h2), view_of(3'h7, 2'h1),
                    view_of(3'h2, 2'h0), view_of(3'h4, 2'h2)})
        bus(1'b1, ipc_pkg::GRP_TWO_ADDR, 32'h0, 4'hf);
        `CHK(got, 32'h061d_0812)
    endtask : layout

    task automatic lanes_unmapped;
        bus(1'b0, ipc_pkg::GRP_ONE_ADDR, 32'h0, 4'h2);
        bus(1'b1, ipc_pkg::GRP_ONE_ADDR, 32'h0, 4'hf);
        `CHK(got, 32'h150a_0003)
        bus(1'b0, 4'h8, 32'hffff_ffff, 4'hf);
        `CHK(got_rsp, 2'h3)
        bus(1'b1, 4'h8, 32'h0, 4'hf);
        `CHK(got, 32'h0)
        bus(1'b1, ipc_pkg::GRP_TWO_ADDR, 32'h0, 4'hf);
        `CHK(got, 32'h061d_0812)
    endtask : lanes_unmapped

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst   = 1'b1;
        rd    = 1'b0;
        wr    = 1'b0;
        addr  = 4'h0;
        wdata = 32'h0;
        ben   = 4'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        code_sweep();
        layout();
        lanes_unmapped();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        reset_values();
        report_and_stop();
    end
endmodule : ipc_priority_regs_tb
